// [rtl/bhd_datapath.sv]
// Byte and half-word integer datapath slice with constants and leading-zero count.
`timescale 1ns/10ps
// Summary of operation
// - High-constant merge replaces upper half of first operand with immediate, keeps low half.
// - Leading-zero count gives zeros preceding the most significant one.
// - Byte order within a word follows the byte-order select bit.
// - Half-word order within a word follows the byte-order select bit too.
// - Byte loads and stores allowed only while narrow access enable is one.
// - Byte load converts packed external byte to unsigned or signed word.
// - Signed character uses byte bit seven as sign.
// - Byte store replicates low source byte into all four lanes.
// - Byte extract replaces only destination low byte with a chosen source byte.
// - Byte taken from first operand is chosen by the lane pointer.
// - Zero destination makes byte extract a zero-extended byte.
// - Byte insert overwrites one chosen destination byte with low source byte.
// - Byte insert may take an immediate character instead of a register source.
// - Byte-lane compare is true when any same-lane bytes are equal.
// - Booleans live in bit 31, one true; compares clear other bits.
// - Half-word loads and stores need narrow enable; load extends signed or unsigned.
// - Signed half-word uses its bit fifteen as sign.
// - Half-word store replicates low source half into both lanes.
// - Half extract replaces destination low half with upper or lower source half.
// - Zero destination makes half extract a zero-extended half-word.
// - Signed half extract fills upper sixteen bits with the sign bit.
// - Half insert overwrites upper or lower destination half with low source half.
module bhd_datapath (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic                          op_valid,
	input  wire bhd_pkg::bhd_op_type           op_code,
	input  wire logic [bhd_pkg::BHD_WORD_W-1:0] first_operand,
	input  wire logic [bhd_pkg::BHD_WORD_W-1:0] second_operand,
	input  wire logic [bhd_pkg::BHD_WORD_W-1:0] result_in,
	input  wire logic [bhd_pkg::BHD_IMM_W-1:0]  immediate,
	input  wire logic                          use_immediate,
	input  wire logic [1:0]                    lane_pointer,
	input  wire logic [1:0]                    addr_low,
	input  wire logic                          load_signed,
	input  wire logic                          byte_order_select,
	input  wire logic                          narrow_access_enable,
	output logic                               result_valid,
	output logic [bhd_pkg::BHD_WORD_W-1:0]     result_register,
	output logic                               store_valid,
	output logic [bhd_pkg::BHD_WORD_W-1:0]     store_data,
	output logic                               narrow_denied
);
	import bhd_pkg::*;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Maps a memory-order lane index to its bit lane; big-endian puts lane 0 at the top.
	function automatic logic [1:0] byte_lane(input logic [1:0] idx, input logic big_end);
		byte_lane = big_end ? ~idx : idx;
	endfunction : byte_lane

	function automatic logic half_lane(input logic idx, input logic big_end);
		half_lane = big_end ? ~idx : idx;
	endfunction : half_lane

	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] lane);
		pick_byte = w[{lane, 3'b000} +: BHD_BYTE_W];
	endfunction : pick_byte

	function automatic logic [15:0] pick_half(input logic [31:0] w, input logic lane);
		pick_half = w[{lane, 4'b0000} +: BHD_HALF_W];
	endfunction : pick_half

	// ------------------------------------------------------------
	// Leading-zero count
	// ------------------------------------------------------------
	logic [BHD_LZC_W-1:0] lzc;

	always_comb begin
		lzc = 6'(BHD_WORD_W);
		for (int i = 0; i < BHD_WORD_W; i++) begin
			if (first_operand[i]) begin
				lzc = 6'(BHD_WORD_W - 1 - i);
			end
		end
	end

	// ------------------------------------------------------------
	// Byte-lane compare
	// ------------------------------------------------------------
	logic [3:0] lane_eq;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_eq[g] = (first_operand[g*8 +: 8] == second_operand[g*8 +: 8]);
		end
	endgenerate

	// ------------------------------------------------------------
	// Lane selection
	// ------------------------------------------------------------
	logic [1:0]  bp_lane;
	logic        hp_lane;
	logic [1:0]  ld_byte_lane;
	logic        ld_half_lane;
	logic [7:0]  sel_byte;
	logic [15:0] sel_half;
	logic [7:0]  ld_byte;
	logic [15:0] ld_half;
	logic [7:0]  ins_byte;

	assign bp_lane      = byte_lane(lane_pointer, byte_order_select);
	assign hp_lane      = half_lane(lane_pointer[1], byte_order_select);
	assign ld_byte_lane = byte_lane(addr_low, byte_order_select);
	assign ld_half_lane = half_lane(addr_low[1], byte_order_select);
	assign sel_byte     = pick_byte(first_operand, bp_lane);
	assign sel_half     = pick_half(first_operand, hp_lane);
	assign ld_byte      = pick_byte(first_operand, ld_byte_lane);
	assign ld_half      = pick_half(first_operand, ld_half_lane);
	assign ins_byte     = use_immediate ? immediate[7:0] : second_operand[7:0];

	// ------------------------------------------------------------
	// Byte and half-word insertion
	// ------------------------------------------------------------
	logic [31:0] ins_byte_word;
	logic [31:0] ins_half_word;

	generate
		for (g = 0; g < 4; g++) begin : g_ins_byte
			assign ins_byte_word[g*8 +: 8] = (bp_lane == 2'(g)) ? ins_byte
				: first_operand[g*8 +: 8];
		end
		for (g = 0; g < 2; g++) begin : g_ins_half
			assign ins_half_word[g*16 +: 16] = (hp_lane == 1'(g)) ? second_operand[15:0]
				: first_operand[g*16 +: 16];
		end
	endgenerate

	// ------------------------------------------------------------
	// Store lane replication
	// ------------------------------------------------------------
	logic [31:0] rep_byte_word;
	logic [31:0] rep_half_word;

	generate
		for (g = 0; g < 4; g++) begin : g_rep_byte
			assign rep_byte_word[g*8 +: 8] = second_operand[7:0];
		end
		for (g = 0; g < 2; g++) begin : g_rep_half
			assign rep_half_word[g*16 +: 16] = second_operand[15:0];
		end
	endgenerate

	// ------------------------------------------------------------
	// Extension of narrow values
	// ------------------------------------------------------------
	logic        byte_fill;
	logic        half_fill;
	logic [31:0] ld_byte_word;
	logic [31:0] ld_half_word;
	logic [31:0] ext_half_word;

	assign byte_fill     = load_signed & ld_byte[7];
	assign half_fill     = load_signed & ld_half[15];
	assign ld_byte_word  = {{24{byte_fill}}, ld_byte};
	assign ld_half_word  = {{16{half_fill}}, ld_half};
	assign ext_half_word = {{BHD_HALF_W{sel_half[15]}}, sel_half};

	// ------------------------------------------------------------
	// Immediate constants
	// ------------------------------------------------------------
	logic [31:0] imm_low_word;
	logic [31:0] imm_high_word;
	logic [31:0] imm_neg_word;

	assign imm_low_word  = {16'h0000, immediate};
	assign imm_high_word = {immediate, first_operand[15:0]};
	assign imm_neg_word  = {BHD_ONES_HALF, immediate};

	// ------------------------------------------------------------
	// Narrow access decode
	// ------------------------------------------------------------
	// Byte and half-word loads and stores are the ones gated by the enable.
	function automatic logic is_narrow_op(input bhd_op_type op);
		case (op)
			BHD_OP_LOAD_BYTE, BHD_OP_LOAD_HALF, BHD_OP_STORE_BYTE, BHD_OP_STORE_HALF: begin
				is_narrow_op = 1'h1;
			end
			default: begin
				is_narrow_op = 1'h0;
			end
		endcase
	endfunction : is_narrow_op

	logic narrow_hit;
	logic narrow_block;

	assign narrow_hit   = op_valid & is_narrow_op(op_code);
	assign narrow_block = narrow_hit & ~narrow_access_enable;

	// ------------------------------------------------------------
	// Result selection
	// ------------------------------------------------------------
	logic [31:0] res_next;
	logic        res_valid_next;
	logic [31:0] store_next;
	logic        store_valid_next;
	logic        denied_next;
	logic [31:0] result_reg;
	logic        result_valid_reg;
	logic [31:0] store_data_reg;
	logic        store_valid_reg;
	logic        denied_reg;

	always_comb begin
		res_next       = result_reg;
		res_valid_next = 1'h0;
		if (op_valid && !narrow_block) begin
			res_valid_next = 1'h1;
			case (op_code)
				BHD_OP_IMM_LOW: begin
					res_next = imm_low_word;
				end
				BHD_OP_IMM_HIGH_MERGE: begin
					res_next = imm_high_word;
				end
				BHD_OP_IMM_NEGATIVE: begin
					res_next = imm_neg_word;
				end
				BHD_OP_LEADING_ZERO: begin
					res_next = {26'h0000000, lzc};
				end
				BHD_OP_BYTE_EXTRACT: begin
					// A zero destination yields the byte zero-extended.
					res_next = {result_in[31:8], sel_byte};
				end
				BHD_OP_BYTE_INSERT: begin
					res_next = ins_byte_word;
				end
				BHD_OP_BYTE_LANE_CMP: begin
					res_next               = BHD_ZERO_WORD;
					res_next[BHD_FLAG_POS] = |lane_eq;
				end
				BHD_OP_HALF_EXTRACT: begin
					res_next = {result_in[31:16], sel_half};
				end
				BHD_OP_HALF_EXTRACT_SGN: begin
					res_next = ext_half_word;
				end
				BHD_OP_HALF_INSERT: begin
					res_next = ins_half_word;
				end
				BHD_OP_LOAD_BYTE: begin
					res_next = ld_byte_word;
				end
				BHD_OP_LOAD_HALF: begin
					res_next = ld_half_word;
				end
				default: begin
					res_valid_next = 1'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Store selection
	// ------------------------------------------------------------
	always_comb begin
		store_next       = store_data_reg;
		store_valid_next = 1'h0;
		if (op_valid && narrow_access_enable) begin
			case (op_code)
				BHD_OP_STORE_BYTE: begin
					store_next       = rep_byte_word;
					store_valid_next = 1'h1;
				end
				BHD_OP_STORE_HALF: begin
					store_next       = rep_half_word;
					store_valid_next = 1'h1;
				end
				default: begin
					store_next       = store_data_reg;
					store_valid_next = 1'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Refusal of narrow accesses
	// ------------------------------------------------------------
	assign denied_next = narrow_block;

	// ------------------------------------------------------------
	// Result word register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			result_reg <= BHD_RESULT_RST;
		end else begin
			result_reg <= res_next;
		end
	end

	// ------------------------------------------------------------
	// Result strobe register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			result_valid_reg <= 1'h0;
		end else begin
			result_valid_reg <= res_valid_next;
		end
	end

	// ------------------------------------------------------------
	// Store word register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			store_data_reg <= BHD_RESULT_RST;
		end else begin
			store_data_reg <= store_next;
		end
	end

	// ------------------------------------------------------------
	// Store strobe register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			store_valid_reg <= 1'h0;
		end else begin
			store_valid_reg <= store_valid_next;
		end
	end

	// ------------------------------------------------------------
	// Refusal strobe register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			denied_reg <= 1'h0;
		end else begin
			denied_reg <= denied_next;
		end
	end

	// ------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------
	assign result_register = result_reg;
	assign result_valid    = result_valid_reg;
	assign store_data      = store_data_reg;
	assign store_valid     = store_valid_reg;
	assign narrow_denied   = denied_reg;

endmodule : bhd_datapath

// [rtl/bhd_pkg.sv]
// Package of operation codes, field positions and reset values for the byte and half-word datapath.
package bhd_pkg;

	// ------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------
	localparam int          BHD_WORD_W     = 32;
	localparam int          BHD_HALF_W     = 16;
	localparam int          BHD_BYTE_W     = 8;
	localparam int          BHD_IMM_W      = 16;
	localparam int          BHD_LZC_W      = 6;
	localparam int          BHD_OP_W       = 4;
	localparam int          BHD_FLAG_POS   = 31;
	localparam logic [31:0] BHD_ZERO_WORD  = 32'h00000000;
	localparam logic [15:0] BHD_ONES_HALF  = 16'hFFFF;
	localparam logic [31:0] BHD_RESULT_RST = 32'h00000000;

	// ------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		BHD_OP_NONE             = 4'h0,
		BHD_OP_IMM_LOW          = 4'h1,
		BHD_OP_IMM_HIGH_MERGE   = 4'h2,
		BHD_OP_IMM_NEGATIVE     = 4'h3,
		BHD_OP_LEADING_ZERO     = 4'h4,
		BHD_OP_BYTE_EXTRACT     = 4'h5,
		BHD_OP_BYTE_INSERT      = 4'h6,
		BHD_OP_BYTE_LANE_CMP    = 4'h7,
		BHD_OP_HALF_EXTRACT     = 4'h8,
		BHD_OP_HALF_EXTRACT_SGN = 4'h9,
		BHD_OP_HALF_INSERT      = 4'hA,
		BHD_OP_LOAD_BYTE        = 4'hB,
		BHD_OP_LOAD_HALF        = 4'hC,
		BHD_OP_STORE_BYTE       = 4'hD,
		BHD_OP_STORE_HALF       = 4'hE
	} bhd_op_type;

endpackage : bhd_pkg

// [tb/bhd_datapath_asserts.sv]
// Port checker for the byte and half-word datapath.
`timescale 1ns/10ps
module bhd_datapath_asserts (
	input wire logic                ref_clk,
	input wire logic                nrst,
	input wire logic                op_valid,
	input wire bhd_pkg::bhd_op_type op_code,
	input wire logic [31:0]         first_operand,
	input wire logic [31:0]         second_operand,
	input wire logic [15:0]         immediate,
	input wire logic [1:0]          lane_pointer,
	input wire logic                byte_order_select,
	input wire logic                narrow_access_enable,
	input wire logic                result_valid,
	input wire logic [31:0]         result_register,
	input wire logic                store_valid,
	input wire logic [31:0]         store_data,
	input wire logic                narrow_denied
);
	import bhd_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire eq_any = (first_operand[7:0] == second_operand[7:0]) |
		(first_operand[15:8] == second_operand[15:8]) |
		(first_operand[23:16] == second_operand[23:16]) |
		(first_operand[31:24] == second_operand[31:24]);
	AST_HIGH: assert property (op_valid && op_code == BHD_OP_IMM_HIGH_MERGE |=> result_valid &&
		result_register == {$past(immediate), $past(first_operand[15:0])}) else $error("high merge");
	AST_NEG: assert property (op_valid && op_code == BHD_OP_IMM_NEGATIVE |=>
		result_register == {BHD_ONES_HALF, $past(immediate)}) else $error("negative constant");
	AST_LZ_ALL: assert property (op_valid && op_code == BHD_OP_LEADING_ZERO &&
		first_operand == 32'h0 |=> result_register == 32'h00000020) else $error("zero count");
	AST_CMP: assert property (op_valid && op_code == BHD_OP_BYTE_LANE_CMP |=>
		result_register == {$past(eq_any), 31'h0}) else $error("lane compare");
	AST_SB: assert property (op_valid && op_code == BHD_OP_STORE_BYTE && narrow_access_enable
		|=> store_valid && store_data == {4{$past(second_operand[7:0])}}) else $error("store byte");
	AST_SH: assert property (op_valid && op_code == BHD_OP_STORE_HALF && narrow_access_enable
		|=> store_valid && store_data == {2{$past(second_operand[15:0])}}) else $error("store half");
	AST_DENY: assert property (op_valid && !narrow_access_enable &&
		op_code inside {[BHD_OP_LOAD_BYTE:BHD_OP_STORE_HALF]} |=>
		narrow_denied && !store_valid && !result_valid) else $error("narrow refusal");
	AST_HSGN: assert property (op_valid && op_code == BHD_OP_HALF_EXTRACT_SGN |=>
		result_register == {{16{result_register[15]}}, $past((lane_pointer[1] ^ byte_order_select) ?
		first_operand[31:16] : first_operand[15:0])}) else $error("half sign fill");
	cover property (op_valid && op_code == BHD_OP_BYTE_EXTRACT);
	cover property (narrow_denied);
	cover property (store_valid);
endmodule : bhd_datapath_asserts

bind bhd_datapath bhd_datapath_asserts chk_u (
	.ref_clk              (ref_clk),
	.nrst                 (nrst),
	.op_valid             (op_valid),
	.op_code              (op_code),
	.first_operand        (first_operand),
	.second_operand       (second_operand),
	.immediate            (immediate),
	.lane_pointer         (lane_pointer),
	.byte_order_select    (byte_order_select),
	.narrow_access_enable (narrow_access_enable),
	.result_valid         (result_valid),
	.result_register      (result_register),
	.store_valid          (store_valid),
	.store_data           (store_data),
	.narrow_denied        (narrow_denied)
);

// [tb/bhd_mem_model.sv]
// Load/store side model that keeps the last outgoing store word.
`timescale 1ns/10ps
module bhd_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        store_valid,
	input  wire logic [31:0] store_data,
	output logic      [31:0] mem_word
);
	always_ff @(posedge ref_clk) begin
		if (store_valid) begin
			mem_word <= store_data;
		end
	end
endmodule : bhd_mem_model

// [tb/tb_top.sv]
// Self-checking testbench of the byte and half-word datapath.
`timescale 1ns/10ps
module tb_top;
	import bhd_pkg::*;
	logic ref_clk = 0, nrst = 0, op_valid = 0, use_immediate = 0, load_signed = 0;
	logic byte_order_select = 0, narrow_access_enable = 1;
	bhd_op_type  op_code = BHD_OP_NONE;
	logic [31:0] first_operand = 0, second_operand = 0, result_in = 0;
	logic [15:0] immediate = 0;
	logic [1:0]  lane_pointer = 0, addr_low = 0;
	logic        result_valid, store_valid, narrow_denied;
	logic [31:0] result_register, store_data, mem_word;
	int          errors = 0, tests_run = 0;
	always #5 ref_clk = ~ref_clk;
	bhd_datapath dut_u (
		.ref_clk              (ref_clk),
		.nrst                 (nrst),
		.op_valid             (op_valid),
		.op_code              (op_code),
		.first_operand        (first_operand),
		.second_operand       (second_operand),
		.result_in            (result_in),
		.immediate            (immediate),
		.use_immediate        (use_immediate),
		.lane_pointer         (lane_pointer),
		.addr_low             (addr_low),
		.load_signed          (load_signed),
		.byte_order_select    (byte_order_select),
		.narrow_access_enable (narrow_access_enable),
		.result_valid         (result_valid),
		.result_register      (result_register),
		.store_valid          (store_valid),
		.store_data           (store_data),
		.narrow_denied        (narrow_denied)
	);
	bhd_mem_model mem_u (
		.ref_clk     (ref_clk),
		.store_valid (store_valid),
		.store_data  (store_data),
		.mem_word    (mem_word)
	);
	task automatic chk_w(logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_w
	task automatic chk_f(logic got, logic exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_f
	task automatic issue(bhd_op_type op, logic [31:0] a, logic [31:0] b);
		@(negedge ref_clk);
		op_code = op;
		first_operand = a;
		second_operand = b;
		op_valid = 1'b1;
		@(negedge ref_clk);
		op_valid = 1'b0;
	endtask : issue
	task automatic op_w(bhd_op_type op, logic [31:0] a, logic [31:0] b, logic [31:0] exp);
		issue(op, a, b);
		chk_f(result_valid, 1'b1);
		chk_w(result_register, exp);
	endtask : op_w
	task automatic t_misc();
		immediate = 16'hABCD;
		op_w(BHD_OP_IMM_HIGH_MERGE, 32'h12345678, 0, 32'hABCD5678);
		op_w(BHD_OP_IMM_LOW, 32'h12345678, 0, 32'h0000ABCD);
		op_w(BHD_OP_IMM_NEGATIVE, 32'h12345678, 0, 32'hFFFFABCD);
		op_w(BHD_OP_BYTE_LANE_CMP, 32'h81F27344, 32'h00F2FF00, 32'h80000000);
		op_w(BHD_OP_BYTE_LANE_CMP, 32'h81F27344, 32'h44738100, 32'h0);
		for (int i = 0; i <= 32; i++) begin
			op_w(BHD_OP_LEADING_ZERO, 32'hFFFFFFFF >> i, 0, 32'(i));
		end
	endtask : t_misc
	task automatic t_lanes();
		logic [31:0] a, e;
		logic [15:0] h;
		logic [7:0]  c;
		int          pos, hs;
		a = 32'h81F27344;
		immediate = 16'h005A;
		for (int k = 0; k < 8; k++) begin
			byte_order_select = k[2];
			lane_pointer = k[1:0];
			addr_low = k[1:0];
			use_immediate = k[1];
			load_signed = k[0];
			result_in = k[0] ? 32'hA5A5A5A5 : 32'h0;
			pos = k[2] ? 3 - k[1:0] : k[1:0];
			hs = k[1] ^ k[2];
			c = a[8*pos +: 8];
			h = a[16*hs +: 16];
			op_w(BHD_OP_BYTE_EXTRACT, a, 32'hB6C3, {result_in[31:8], c});
			op_w(BHD_OP_HALF_EXTRACT, a, 32'hB6C3, {result_in[31:16], h});
			op_w(BHD_OP_HALF_EXTRACT_SGN, a, 32'hB6C3, {{16{h[15]}}, h});
			op_w(BHD_OP_LOAD_BYTE, a, 0, k[0] ? {{24{c[7]}}, c} : {24'h0, c});
			op_w(BHD_OP_LOAD_HALF, a, 0, k[0] ? {{16{h[15]}}, h} : {16'h0, h});
			e = a;
			e[8*pos +: 8] = k[1] ? 8'h5A : 8'hC3;
			op_w(BHD_OP_BYTE_INSERT, a, 32'hB6C3, e);
			e = a;
			e[16*hs +: 16] = 16'hB6C3;
			op_w(BHD_OP_HALF_INSERT, a, 32'hB6C3, e);
		end
	endtask : t_lanes
	task automatic t_narrow();
		issue(BHD_OP_STORE_BYTE, 0, 32'h1234B6C3);
		chk_f(store_valid, 1'b1);
		chk_w(store_data, 32'hC3C3C3C3);
		issue(BHD_OP_STORE_HALF, 0, 32'h1234B6C3);
		chk_w(store_data, 32'hB6C3B6C3);
		@(negedge ref_clk);
		chk_f(store_valid, 1'b0);
		chk_w(mem_word, 32'hB6C3B6C3);
		narrow_access_enable = 1'b0;
		for (int k = 11; k < 15; k++) begin
			issue(bhd_op_type'(k), 32'h81F27344, 32'hB6C3);
			chk_f(narrow_denied, 1'b1);
			chk_f(result_valid | store_valid, 1'b0);
			chk_w(result_register, 32'h81F2B6C3);
			chk_w(store_data, 32'hB6C3B6C3);
		end
	endtask : t_narrow
	task automatic summarize();
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		t_misc();
		t_lanes();
		t_narrow();
		summarize();
	end
endmodule : tb_top
